// ===== hdl/ufbs_top.sv
// Overview of operation
// - Normal-speed receive takes sixteen samples per bit, three middle ones vote.
// - Baud counter counts down repeatedly, ticking at zero; sampling runs per tick.
// - Negative exponent adds one extra cycle to selected periods, raising average.
// - Divisor zero gives 160 cycles per ten-bit frame, divisor one gives 320.
// - Exponent -1 with divisor one gives 240 cycles per ten-bit frame.
// - At 32 MHz divisor zero gives 2M baud, double speed 4M baud.
// - In master SPI mode an enabled receiver captures the serial input.
// - In master SPI mode the device drives the transfer clock pin.
// - Every SPI transfer starts only when software writes the data location.
// - Buffered data enters the shift register only when it can start a frame.
// - Transmit and receive flags behave as in asynchronous operation.
// - Receiver error flags read zero in master SPI mode.
// - Disabling transmitter or receiver in SPI mode acts as in normal mode.
// - Clock phase and bit order selects act as standard SPI phase and order.
// - SPI waveform timing matches a standalone SPI master.
// - A transmit buffer sits ahead of the shift register for queueing.
// - Receive buffer holds two entries, one more than a plain SPI receiver.
// - No write collision detection exists in master SPI mode.
// - No SPI double-rate option; faster clocks come from the baud generator.
// - Serial out is MOSI, serial in is MISO, transfer clock is SCK, no select.
// - Double speed receive takes eight samples per bit.
`timescale 1ns/10ps
`default_nettype none
module ufbs_top
    import ufbs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spi_mode,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic double_speed_select,
    input wire logic clock_phase_select,
    input wire logic bit_order_select,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic [SCALE_W-1:0] baud_scale_exponent,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic tx_write,
    output logic data_reg_empty,
    output logic tx_complete,
    input wire logic tx_complete_clear,
    output logic [DATA_W-1:0] rx_data,
    output logic rx_complete,
    input wire logic rx_read,
    output logic frame_error,
    output logic buffer_overflow,
    output logic txd_out,
    input wire logic rxd_in,
    output logic transfer_clock_pin
);
    ufbs_baud_if bif ();
    assign bif.divisor = baud_divisor;
    assign bif.scale = baud_scale_exponent;

    ufbs_baud_gen u_baud (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .bif(bif)
    );

    generate
        if (RX_DEPTH != 2 || DATA_W != 8) begin : g_bad
            $error("ufbs_top: receive buffer must hold two bytes");
        end
    endgenerate

    function automatic logic pick(input logic [DATA_W-1:0] d, input logic [2:0] k,
                                  input logic lsb_first);
        pick = lsb_first ? d[k] : d[3'(DATA_W-1) - k];
    endfunction

    // Input synchroniser: level changes once second and third stage agree
    logic rx_s1_r, rx_s2_r, rx_s3_r, rxd_lvl_r, rxd_lvl_nxt;
    always_comb begin
        rxd_lvl_nxt = (rx_s2_r == rx_s3_r) ? rx_s3_r : rxd_lvl_r;
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
            rxd_lvl_r <= 1'b1;
        end else begin
            rx_s1_r <= rxd_in;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            rxd_lvl_r <= rxd_lvl_nxt;
        end
    end

    logic [4:0] samples, vote_first;
    always_comb begin
        samples = double_speed_select ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
        vote_first = double_speed_select ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    end

    // Transmit side
    ufbs_tx_state_t tx_st_r, tx_st_nxt;
    logic buf_full_r, buf_full_nxt;
    logic [DATA_W-1:0] buf_r, buf_nxt, tsh_r, tsh_nxt, rsh_spi_r, rsh_spi_nxt;
    logic [3:0] tbit_r, tbit_nxt;
    logic [4:0] ttick_r, ttick_nxt;
    logic txd_r, txd_nxt, xck_r, xck_nxt, txc_r, txc_nxt;
    logic tx_done, spi_push, leading, sample_edge;
    logic [2:0] kidx;

    always_comb begin
        tx_st_nxt = tx_st_r;
        buf_full_nxt = buf_full_r;
        buf_nxt = buf_r;
        tsh_nxt = tsh_r;
        rsh_spi_nxt = rsh_spi_r;
        tbit_nxt = tbit_r;
        ttick_nxt = ttick_r;
        txd_nxt = txd_r;
        xck_nxt = xck_r;
        txc_nxt = txc_r;
        tx_done = 1'b0;
        spi_push = 1'b0;
        leading = !xck_r;
        kidx = tbit_r[3:1];
        sample_edge = leading ^ clock_phase_select;
        // Writes while the buffer is full are dropped silently
        if (tx_write && !buf_full_r) begin
            buf_full_nxt = 1'b1;
            buf_nxt = tx_data;
        end
        unique case (tx_st_r)
            TX_IDLE: begin
                xck_nxt = 1'b0;
                txd_nxt = spi_mode ? txd_r : 1'b1;
                // Start on a baud tick so the first bit gets its full length
                if (buf_full_r && tx_enable && bif.tick) begin
                    buf_full_nxt = 1'b0;
                    tsh_nxt = buf_r;
                    tbit_nxt = '0;
                    ttick_nxt = '0;
                    if (spi_mode) begin
                        tx_st_nxt = TX_SPI;
                        if (!clock_phase_select) begin
                            txd_nxt = pick(buf_r, 3'h0, bit_order_select);
                        end
                    end else begin
                        tx_st_nxt = TX_ASYNC;
                        txd_nxt = 1'b0;
                    end
                end
            end
            TX_ASYNC: begin
                if (bif.tick) begin
                    ttick_nxt = ttick_r + 5'h01;
                    if (ttick_r == samples - 5'h01) begin
                        ttick_nxt = '0;
                        tbit_nxt = tbit_r + 4'h1;
                        if (tbit_r == FRAME_LAST_BIT) begin
                            tx_done = 1'b1;
                        end else if (tbit_r == FRAME_LAST_BIT - 4'h1) begin
                            txd_nxt = 1'b1;
                        end else begin
                            txd_nxt = tsh_r[tbit_r[2:0]];
                        end
                    end
                end
            end
            TX_SPI: begin
                // One baud tick per half period of the transfer clock
                if (bif.tick) begin
                    xck_nxt = !xck_r;
                    tbit_nxt = tbit_r + 4'h1;
                    if (sample_edge) begin
                        rsh_spi_nxt[bit_order_select ? kidx : SPI_LAST_BIT - kidx] = rxd_lvl_r;
                    end
                    if (clock_phase_select && leading) begin
                        txd_nxt = pick(tsh_r, kidx, bit_order_select);
                    end else if (!clock_phase_select && !leading && kidx != SPI_LAST_BIT) begin
                        txd_nxt = pick(tsh_r, kidx + 3'h1, bit_order_select);
                    end
                    if (tbit_r == SPI_LAST_HALF) begin
                        tx_done = 1'b1;
                        spi_push = rx_enable;
                    end
                end
            end
            default: tx_st_nxt = TX_IDLE;
        endcase
        if (tx_done) begin
            tx_st_nxt = TX_IDLE;
        end
        if (!tx_enable) begin
            buf_full_nxt = 1'b0;
        end
        // A frame ending in the clearing cycle still sets the flag
        if (tx_complete_clear) begin
            txc_nxt = 1'b0;
        end
        if (tx_done && !buf_full_r) begin
            txc_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_st_r <= TX_IDLE;
            buf_full_r <= 1'b0;
            buf_r <= DATA_RESET;
            tsh_r <= DATA_RESET;
            rsh_spi_r <= DATA_RESET;
            tbit_r <= '0;
            ttick_r <= '0;
            txd_r <= 1'b1;
            xck_r <= 1'b0;
            txc_r <= 1'b0;
        end else begin
            tx_st_r <= tx_st_nxt;
            buf_full_r <= buf_full_nxt;
            buf_r <= buf_nxt;
            tsh_r <= tsh_nxt;
            rsh_spi_r <= rsh_spi_nxt;
            tbit_r <= tbit_nxt;
            ttick_r <= ttick_nxt;
            txd_r <= txd_nxt;
            xck_r <= xck_nxt;
            txc_r <= txc_nxt;
        end
    end

    // Asynchronous receive side
    ufbs_rx_state_t rx_st_r, rx_st_nxt;
    logic [4:0] scnt_r, scnt_nxt, nidx;
    logic [3:0] rbit_r, rbit_nxt;
    logic [1:0] votes_r, votes_nxt, vsum;
    logic [DATA_W-1:0] rsh_r, rsh_nxt;
    logic async_push, async_fe, bit_val;

    always_comb begin
        rx_st_nxt = rx_st_r;
        scnt_nxt = scnt_r;
        rbit_nxt = rbit_r;
        votes_nxt = votes_r;
        rsh_nxt = rsh_r;
        async_push = 1'b0;
        async_fe = 1'b0;
        nidx = (scnt_r == samples) ? 5'h01 : scnt_r + 5'h01;
        vsum = votes_r + 2'(rxd_lvl_r);
        bit_val = vsum[1];
        unique case (rx_st_r)
            RX_IDLE: begin
                if (bif.tick && !rxd_lvl_r) begin
                    rx_st_nxt = RX_BITS;
                    scnt_nxt = 5'h01;
                    rbit_nxt = '0;
                    votes_nxt = '0;
                end
            end
            RX_BITS: begin
                if (bif.tick) begin
                    scnt_nxt = nidx;
                    if (nidx >= vote_first && nidx <= vote_first + VOTE_SPAN) begin
                        votes_nxt = vsum;
                    end
                    if (nidx == vote_first + VOTE_SPAN) begin
                        votes_nxt = '0;
                        rbit_nxt = rbit_r + 4'h1;
                        if (rbit_r == '0 && bit_val) begin
                            rx_st_nxt = RX_IDLE;
                        end else if (rbit_r == FRAME_STOP_BIT) begin
                            rx_st_nxt = RX_IDLE;
                            async_push = 1'b1;
                            async_fe = !bit_val;
                        end else if (rbit_r != '0) begin
                            rsh_nxt = {bit_val, rsh_r[DATA_W-1:1]};
                        end
                    end
                end
            end
        endcase
        if (!rx_enable || spi_mode) begin
            rx_st_nxt = RX_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_st_r <= RX_IDLE;
            scnt_r <= '0;
            rbit_r <= '0;
            votes_r <= '0;
            rsh_r <= DATA_RESET;
        end else begin
            rx_st_r <= rx_st_nxt;
            scnt_r <= scnt_nxt;
            rbit_r <= rbit_nxt;
            votes_r <= votes_nxt;
            rsh_r <= rsh_nxt;
        end
    end

    // Two-entry receive buffer
    logic [DATA_W-1:0] fdat_r [RX_DEPTH];
    logic [DATA_W-1:0] fdat_nxt [RX_DEPTH];
    logic [RX_DEPTH-1:0] ffe_r, ffe_nxt;
    logic [1:0] fcnt_r, fcnt_nxt;
    logic frp_r, frp_nxt, ovf_r, ovf_nxt, push, pop, wp;

    always_comb begin
        fdat_nxt = fdat_r;
        ffe_nxt = ffe_r;
        fcnt_nxt = fcnt_r;
        frp_nxt = frp_r;
        ovf_nxt = ovf_r;
        push = async_push || spi_push;
        pop = rx_read && fcnt_r != 2'h0;
        wp = frp_r ^ fcnt_r[0];
        if (pop) begin
            frp_nxt = !frp_r;
            ovf_nxt = 1'b0;
        end
        if (push && (fcnt_r != 2'(RX_DEPTH) || pop)) begin
            // Next value keeps a bit sampled on the final clock edge
            fdat_nxt[pop && fcnt_r == 2'(RX_DEPTH) ? frp_r : wp] = spi_mode ? rsh_spi_nxt : rsh_r;
            ffe_nxt[pop && fcnt_r == 2'(RX_DEPTH) ? frp_r : wp] = async_fe;
        end else if (push) begin
            ovf_nxt = 1'b1;
        end
        fcnt_nxt = fcnt_r + 2'(push && (fcnt_r != 2'(RX_DEPTH) || pop)) - 2'(pop);
        if (!rx_enable) begin
            fcnt_nxt = '0;
            ovf_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fdat_r <= '{default: DATA_RESET};
            ffe_r <= '0;
            fcnt_r <= '0;
            frp_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            fdat_r <= fdat_nxt;
            ffe_r <= ffe_nxt;
            fcnt_r <= fcnt_nxt;
            frp_r <= frp_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    assign data_reg_empty = !buf_full_r;
    assign tx_complete = txc_r;
    assign rx_data = fdat_r[frp_r];
    assign rx_complete = (fcnt_r != 2'h0);
    assign frame_error = ffe_r[frp_r] && !spi_mode && rx_complete;
    assign buffer_overflow = ovf_r && !spi_mode;
    assign txd_out = txd_r;
    assign transfer_clock_pin = xck_r && spi_mode;

    // Checks
    logic [3:0] rise_cnt_r;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || tx_st_r == TX_IDLE) begin
            rise_cnt_r <= '0;
        end else if (bif.tick && !xck_r && tx_st_r == TX_SPI) begin
            rise_cnt_r <= rise_cnt_r + 4'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_buffer_to_shifter: assert property (
        tx_st_r == TX_IDLE && buf_full_r && tx_enable && bif.tick
        |=> tx_st_r != TX_IDLE && !buf_full_r)
        else $error("queued byte not moved into idle shifter");
    a_start_needs_write: assert property (
        tx_st_r == TX_IDLE ##1 tx_st_r != TX_IDLE |-> $past(buf_full_r))
        else $error("transfer started without written data");
    a_spi_clock_idle: assert property (
        tx_st_r != TX_SPI |-> !transfer_clock_pin)
        else $error("transfer clock active outside a transfer");
    a_spi_eight_edges: assert property (
        tx_st_r == TX_SPI && tx_done |-> rise_cnt_r == 4'h8 ##2 rise_cnt_r == 4'h0)
        else $error("SPI frame without eight clock pulses");
    a_spi_no_errors: assert property (
        spi_mode |-> !frame_error && !buffer_overflow)
        else $error("error flag visible in SPI mode");
    a_txc_set_wins: assert property (
        tx_done && !buf_full_r && tx_complete_clear |=> tx_complete)
        else $error("completion lost against clear");
    a_rx_flush_off: assert property (
        !rx_enable |=> !rx_complete ##1 !rx_complete)
        else $error("receive buffer not flushed when disabled");
    a_rx_vote_slot: assert property (
        async_push |-> scnt_nxt == vote_first + VOTE_SPAN)
        else $error("stop bit decided outside middle samples");
    a_spi_rx_store: assert property (
        spi_push |=> rx_complete && rx_data == $past(rsh_spi_nxt) || $past(fcnt_r) != 2'h0)
        else $error("SPI byte not stored");

    c_spi_frame: cover property (tx_st_r == TX_SPI && tx_done && spi_push);
    c_async_frame: cover property (async_push && !async_fe);
    c_overflow: cover property (push && fcnt_r == 2'(RX_DEPTH) && !pop);
endmodule
`default_nettype wire

// ===== hdl/ufbs_pkg.sv
package ufbs_pkg;
    localparam int DIV_W = 12;
    localparam int SCALE_W = 4;
    localparam int DATA_W = 8;
    localparam int RX_DEPTH = 2;
    localparam int CNT_W = 20;
    localparam int ACC_W = 8;
    localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
    localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] VOTE_SPAN = 5'h02;
    localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
    localparam logic [3:0] FRAME_STOP_BIT = 4'h9;
    localparam logic [3:0] SPI_LAST_HALF = 4'hf;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [SCALE_W-1:0] SCALE_RESET = 4'h0;
    localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SPI} ufbs_tx_state_t;
    typedef enum logic {RX_IDLE, RX_BITS} ufbs_rx_state_t;
endpackage

// ===== hdl/ufbs_baud_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ufbs_baud_if;
    import ufbs_pkg::*;
    logic [DIV_W-1:0] divisor;
    logic [SCALE_W-1:0] scale;
    logic tick;
    modport gen (input divisor, input scale, output tick);
    modport user (output divisor, output scale, input tick);
endinterface
`default_nettype wire

// ===== hdl/ufbs_baud_gen.sv
`timescale 1ns/10ps
`default_nettype none
module ufbs_baud_gen
    import ufbs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    ufbs_baud_if.gen bif
);
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [ACC_W-1:0] acc_r, acc_nxt;
    logic [SCALE_W-1:0] mag;
    logic [ACC_W-1:0] one_mag, frac, sum;
    logic [CNT_W-1:0] reload;
    logic carry;

    generate
        if (DIV_W < 1 || SCALE_W != 4 || ACC_W < 8) begin : g_bad
            $error("ufbs_baud_gen: unsupported widths");
        end
    endgenerate

    assign bif.tick = (cnt_r == '0);

    // Positive exponent stretches the whole period; negative adds fractional cycles
    always_comb begin
        mag = bif.scale[SCALE_W-1] ? SCALE_W'(-bif.scale) : bif.scale;
        one_mag = ACC_W'(1) << mag;
        frac = ACC_W'(bif.divisor) & (one_mag - ACC_W'(1));
        sum = acc_r + frac;
        carry = 1'b0;
        acc_nxt = acc_r;
        if (bif.scale[SCALE_W-1]) begin
            carry = (sum >= one_mag);
            reload = CNT_W'(bif.divisor >> mag) + CNT_W'(carry);
        end else begin
            reload = (CNT_W'(bif.divisor + 1'b1) << bif.scale) - CNT_W'(1);
        end
        cnt_nxt = cnt_r - CNT_W'(1);
        if (bif.tick) begin
            cnt_nxt = reload;
            if (bif.scale[SCALE_W-1]) begin
                acc_nxt = carry ? sum - one_mag : sum;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            acc_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            acc_r <= acc_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_fastest_every_cycle: assert property (
        (bif.divisor == DIV_RESET && bif.scale == SCALE_RESET)[*2] |-> bif.tick)
        else $error("divisor zero must tick every cycle");
    a_half_frac_gap: assert property (
        (bif.divisor == 12'h001 && bif.scale == 4'hf)[*3] |-> (bif.tick || $past(bif.tick)))
        else $error("half-cycle fraction must not skip two cycles");
    a_half_frac_extra: assert property (
        (bif.divisor == 12'h001 && bif.scale == 4'hf)[*4] |-> !(bif.tick && $past(bif.tick)
        && $past(bif.tick, 2)))
        else $error("half-cycle fraction must insert extra cycles");
    c_frac_extra: cover property (bif.scale[SCALE_W-1] && carry && bif.tick);
endmodule
`default_nettype wire

// ===== verification/ufbs_spi_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module ufbs_spi_slave_model (
    input wire logic sys_clk,
    input wire logic sck,
    input wire logic mosi,
    input wire logic spi_mode,
    input wire logic cpha,
    input wire logic lsb,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got,
    output int rises
);
    logic sck_q = 1'b0;
    logic [2:0] r = 3'h0;
    logic [2:0] f = 3'h0;
    logic [2:0] k;
    logic [7:0] g = 8'h00;
    int cnt = 0;
    function automatic logic [2:0] pos(input logic [2:0] c);
        return lsb ? c : 3'h7 - c;
    endfunction
    assign k = cpha ? r - 3'h1 : f;
    // Async mode loops the serial line back; SPI mode answers as a slave
    assign miso = spi_mode ? reply[pos(k)] : mosi;
    assign got = g;
    assign rises = cnt;
    always @(posedge sys_clk) begin
        sck_q <= sck;
        if (sck && !sck_q) begin
            r <= r + 3'h1;
            cnt <= cnt + 1;
            if (!cpha) g[pos(r)] <= mosi;
        end
        if (!sck && sck_q) begin
            f <= f + 3'h1;
            if (cpha) g[pos(f)] <= mosi;
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb_ufbs_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ufbs_top;
    import ufbs_pkg::*;
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [SCALE_W-1:0] scale;
        logic dbl;
        logic [15:0] low;
    } ufbs_row_t;
    localparam int N_ROWS = 7;
    // Byte 0x80 sent LSB first holds the line low for eight bit times
    localparam ufbs_row_t ROWS [N_ROWS] = '{
        '{12'h000, 4'h0, 1'b0, 16'h0080},
        '{12'h001, 4'h0, 1'b0, 16'h0100},
        '{12'h001, 4'hf, 1'b0, 16'h00c0},
        '{12'h003, 4'he, 1'b0, 16'h00e0},
        '{12'h002, 4'h0, 1'b0, 16'h0180},
        '{12'h000, 4'h1, 1'b0, 16'h0100},
        '{12'h000, 4'h0, 1'b1, 16'h0040}};
    logic sys_clk = 1'b0;
    logic rst_n, spi_mode, tx_enable, rx_enable, dbl, cpha, lsb, tx_write, tx_clr, rx_read;
    logic [DIV_W-1:0] div;
    logic [SCALE_W-1:0] scale;
    logic [7:0] tx_data, reply, got, rx_data;
    logic data_reg_empty, tx_complete, rx_complete, frame_error, buffer_overflow;
    logic txd_out, rxd_in, sck;
    int rises, fails, tests_run, cycles, n, base;
    always #10 sys_clk = ~sys_clk;
    ufbs_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_mode(spi_mode),
        .tx_enable(tx_enable), .rx_enable(rx_enable), .double_speed_select(dbl),
        .clock_phase_select(cpha), .bit_order_select(lsb), .baud_divisor(div),
        .baud_scale_exponent(scale), .tx_data(tx_data), .tx_write(tx_write),
        .data_reg_empty(data_reg_empty), .tx_complete(tx_complete),
        .tx_complete_clear(tx_clr), .rx_data(rx_data), .rx_complete(rx_complete),
        .rx_read(rx_read), .frame_error(frame_error), .buffer_overflow(buffer_overflow),
        .txd_out(txd_out), .rxd_in(rxd_in), .transfer_clock_pin(sck));
    ufbs_spi_slave_model slave (.sys_clk(sys_clk), .sck(sck), .mosi(txd_out),
        .spi_mode(spi_mode), .cpha(cpha), .lsb(lsb), .reply(reply), .miso(rxd_in),
        .got(got), .rises(rises));
    task automatic give_verdict();
        $display("Checks run: %0d, mismatches: %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic sel(input int w);
        return w == 0 ? data_reg_empty : w == 1 ? tx_complete :
            w == 2 ? rx_complete : buffer_overflow;
    endfunction
    task automatic wait_on(input int w);
        int c;
        c = 0;
        do begin
            @(posedge sys_clk);
            c++;
        end while (sel(w) !== 1'b1 && c < 5000);
        if (sel(w) !== 1'b1) fails++;
    endtask
    task automatic send(input logic [7:0] d);
        wait_on(0);
        tx_data <= d;
        tx_write <= 1'b1;
        @(posedge sys_clk);
        tx_write <= 1'b0;
    endtask
    task automatic read_rx();
        rx_read <= 1'b1;
        @(posedge sys_clk);
        rx_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        {rst_n, spi_mode, tx_enable, rx_enable, dbl, cpha, lsb, tx_write, tx_clr, rx_read} = 0;
        div = 12'h000;
        scale = 4'h0;
        tx_data = 8'h00;
        reply = 8'hc5;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        tx_enable <= 1'b1;
        rx_enable <= 1'b1;
        for (int i = 0; i < N_ROWS; i++) begin
            div <= ROWS[i].div;
            scale <= ROWS[i].scale;
            dbl <= ROWS[i].dbl;
            @(posedge sys_clk);
            send(8'h80);
            n = 0;
            while (txd_out !== 1'b0) @(posedge sys_clk);
            while (txd_out === 1'b0) begin
                n++;
                @(posedge sys_clk);
            end
            check(n, ROWS[i].low);
            wait_on(1);
            check(tx_complete, 1'b1);
            tx_clr <= 1'b1;
            @(posedge sys_clk);
            tx_clr <= 1'b0;
            wait_on(2);
            check(rx_data, 8'h80);
            check(frame_error, 1'b0);
            read_rx();
        end
        // Reset in mid-frame returns txd_out, sck, data_reg_empty and both complete flags to idle
        div <= 12'h000;
        scale <= 4'h0;
        dbl <= 1'b0;
        send(8'h55);
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check({txd_out, sck, data_reg_empty, tx_complete, rx_complete}, 5'h14);
        rst_n <= 1'b1;
        // Three queued frames against a two-entry receive buffer
        send(8'h11);
        send(8'h22);
        send(8'h33);
        wait_on(3);
        check(buffer_overflow, 1'b1);
        check(rx_data, 8'h11);
        read_rx();
        check(rx_data, 8'h22);
        read_rx();
        check({rx_complete, buffer_overflow}, 2'h0);
        spi_mode <= 1'b1;
        div <= 12'h007;
        base = rises;
        repeat (50) @(posedge sys_clk);
        check(rises - base, 0);
        for (int m = 0; m < 4; m++) begin
            cpha <= m[0];
            lsb <= m[1];
            @(posedge sys_clk);
            base = rises;
            send(8'h1d);
            wait_on(2);
            repeat (4) @(posedge sys_clk);
            check(rx_data, 8'hc5);
            check(got, 8'h1d);
            check(rises - base, 8);
            check({frame_error, buffer_overflow, sck}, 3'h0);
            read_rx();
        end
        // Disabling flushes the buffers while the running transfer finishes
        base = rises;
        send(8'h3c);
        send(8'h3c);
        tx_enable <= 1'b0;
        @(posedge sys_clk);
        tx_enable <= 1'b1;
        @(posedge sys_clk);
        check(data_reg_empty, 1'b1);
        wait_on(2);
        rx_enable <= 1'b0;
        @(posedge sys_clk);
        rx_enable <= 1'b1;
        @(posedge sys_clk);
        check(rx_complete, 1'b0);
        repeat (300) @(posedge sys_clk);
        check(rises - base, 8);
        give_verdict();
    end
endmodule
`default_nettype wire
